// ### core/battery_fault_latch_protect.sv
// Protection decisions for a battery monitor: tier three discharge overcurrent,
// discharge overcurrent and short-circuit latches, charge/discharge overtemperature.
// Assumes current and temperature are synchronous to CORE_CLK_I and that
// detector events are one-cycle pulses.
//
// How it works
// [RL1] Tier three overcurrent fault sets after condition persists 0..255 s, default 2.
// [RL2] Shared 200 mA threshold; current at or above it for recovery time clears.
// [RL3] Every overcurrent event bumps an 8-bit latch count; reaching limit raises fault.
// [RL4] Nonzero latch counts drop by one each programmed delay, default 10 s.
// [RL5] Overcurrent latch clears when current stays at/above 200 mA for 15 s.
// [RL6] Latch current recovery works only while its enable bit is set.
// [RL7] Every short-circuit event bumps an 8-bit latch count; reaching limit raises fault.
// [RL8] Short-circuit latch clears when current stays at/above 200 mA for its time.
// [RL9] Charge overtemperature trips at max cell temp at/above signed threshold, default 55.
// [RL10] Charge overtemperature delay programmable 0..255 s, default 2 s.
// [RL11] Charge overtemperature check ignores current direction.
// [RL12] Charge overtemperature recovers at/below 50 C for the general recovery time.
// [RL13] Discharge overtemperature trips at/above 60 C for its delay.
// [RL14] Discharge overtemperature delay programmable 0..255 s, default 2 s.
// [RL15] Discharge overtemperature check ignores whether current flows.
// [RL16] Discharge overtemperature recovers at/below 55 C for the general recovery time.
// [RL17] Persistence timers count whole seconds and restart when the condition lapses.
// [RL18] General recovery time is an 8-bit input in seconds, shared by non-latch recoveries.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module battery_fault_latch_protect
  import protect_pkg::*;
#(
  parameter int TICK_CYCLES = SECOND_CYCLES
)
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_N_I,
  // AXI4-Lite slave
  input  wire logic [11:0] S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [11:0] S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  // Measurements and detector events
  input  wire logic [15:0] CURRENT_I,
  input  wire logic [7:0]  MAX_CELL_TEMP_I,
  input  wire logic        DISCHARGE_OVERCURRENT_EVENT_I,
  input  wire logic        DISCHARGE_SHORT_CIRCUIT_EVENT_I,
  input  wire logic [7:0]  RECOVERY_TIME_I,
  // Fault and recovery flags
  output logic             DISCHARGE_OVERCURRENT_TIER_THREE_FAULT_O,
  output logic             DISCHARGE_OVERCURRENT_RECOVERED_O,
  output logic             DISCHARGE_OVERCURRENT_LATCH_FAULT_O,
  output logic             DISCHARGE_SHORT_CIRCUIT_LATCH_FAULT_O,
  output logic             CHARGE_OVERTEMPERATURE_FAULT_O,
  output logic             DISCHARGE_OVERTEMPERATURE_FAULT_O
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [NUM_CFG-1:0][31:0] cfg;
    logic [TICK_W-1:0]        tick_cnt;
    logic                     tick;
    logic [11:0]              awaddr;
    logic                     aw_full;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     w_full;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    logic [7:0]               ocl_cnt;
    logic [7:0]               scl_cnt;
    logic                     t3_flt;
    logic                     ocd_rec;
    logic                     ocl_flt;
    logic                     scl_flt;
    logic                     otc_flt;
    logic                     otd_flt;
  } core_state_t;

  localparam core_state_t RESET_STATE = '{cfg: CFG_RESET, default: '0};

  core_state_t q;
  core_state_t d;

  logic [NUM_TIMERS-1:0]      t_cond;
  logic [NUM_TIMERS-1:0]      t_clr;
  logic [NUM_TIMERS-1:0][7:0] t_lim;
  logic [NUM_TIMERS-1:0]      t_done;

  logic signed [15:0] cur;
  logic signed [7:0]  temp;
  logic               awready;
  logic               wready;
  logic               arready;
  logic [3:0]         wr_idx;
  logic [3:0]         rd_idx;
  logic               wr_map;
  logic               rd_map;
  logic [31:0]        status_word;

  assign cur  = $signed(CURRENT_I);
  assign temp = $signed(MAX_CELL_TEMP_I);

  // Count step with saturation at both ends; increment and decrement cancel
  function automatic logic [7:0] step_cnt(
    input logic [7:0] cnt,
    input logic       inc,
    input logic       dec
  );
    logic [7:0] r;
    r = cnt;
    if (inc && !dec && cnt != CNT_MAX) begin
      r = cnt + 8'h01;
    end else if (dec && !inc && cnt != 8'h00) begin
      r = cnt - 8'h01;
    end
    return r;
  endfunction : step_cnt

  // Persistence conditions and limits
  always_comb begin
    t_clr = '0;

    t_cond[TM_T3] = !q.t3_flt && (cur <= $signed(q.cfg[IDX_T3_CFG][15:0]));                  // [RL1]
    t_lim[TM_T3]  = q.cfg[IDX_T3_CFG][FLD_B2 +: 8];                                          // [RL1]

    t_cond[TM_OCD_REC] = cur >= $signed(q.cfg[IDX_OCD_REC][15:0]);                           // [RL2]
    t_lim[TM_OCD_REC]  = RECOVERY_TIME_I;                                                    // [RL18]

    t_cond[TM_OCL_REC] = q.ocl_flt && q.cfg[IDX_CTRL][CTRL_OCL_EN]                           // [RL6]
                         && (cur >= $signed(q.cfg[IDX_OCL_REC][15:0]));                      // [RL5]
    t_lim[TM_OCL_REC]  = q.cfg[IDX_OCL_CFG][FLD_B2 +: 8];                                    // [RL5]

    t_cond[TM_SCL_REC] = q.scl_flt && q.cfg[IDX_CTRL][CTRL_SCL_EN]                           // [RL6]
                         && (cur >= $signed(q.cfg[IDX_SCL_REC][15:0]));                      // [RL8]
    t_lim[TM_SCL_REC]  = q.cfg[IDX_SCL_CFG][FLD_B2 +: 8];                                    // [RL8]

    // Temperature checks take no notice of current direction
    t_cond[TM_OTC_SET] = !q.otc_flt && (temp >= $signed(q.cfg[IDX_OTC_CFG][FLD_B0 +: 8]));   // [RL9] [RL11]
    t_lim[TM_OTC_SET]  = q.cfg[IDX_OTC_CFG][FLD_B1 +: 8];                                    // [RL10]
    t_cond[TM_OTC_REC] = q.otc_flt && (temp <= $signed(q.cfg[IDX_OTC_CFG][FLD_B2 +: 8]));    // [RL12]
    t_lim[TM_OTC_REC]  = RECOVERY_TIME_I;                                                    // [RL18]

    t_cond[TM_OTD_SET] = !q.otd_flt && (temp >= $signed(q.cfg[IDX_OTD_CFG][FLD_B0 +: 8]));   // [RL13] [RL15]
    t_lim[TM_OTD_SET]  = q.cfg[IDX_OTD_CFG][FLD_B1 +: 8];                                    // [RL14]
    t_cond[TM_OTD_REC] = q.otd_flt && (temp <= $signed(q.cfg[IDX_OTD_CFG][FLD_B2 +: 8]));    // [RL16]
    t_lim[TM_OTD_REC]  = RECOVERY_TIME_I;                                                    // [RL18]

    // Decay timers restart after every decrement
    t_cond[TM_OCL_DEC] = q.ocl_cnt != 8'h00;                                                 // [RL4]
    t_lim[TM_OCL_DEC]  = q.cfg[IDX_OCL_CFG][FLD_B1 +: 8];                                    // [RL4]
    t_clr[TM_OCL_DEC]  = t_done[TM_OCL_DEC];                                                 // [RL4]
    t_cond[TM_SCL_DEC] = q.scl_cnt != 8'h00;                                                 // [RL4]
    t_lim[TM_SCL_DEC]  = q.cfg[IDX_SCL_CFG][FLD_B1 +: 8];                                    // [RL4]
    t_clr[TM_SCL_DEC]  = t_done[TM_SCL_DEC];                                                 // [RL4]
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer
      persist_timer u_timer (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .tick_i  (q.tick),
        .cond_i  (t_cond[gi]),
        .clr_i   (t_clr[gi]),
        .limit_i (t_lim[gi]),
        .done_o  (t_done[gi])
      );
    end
  endgenerate

  // Bus decode
  assign awready = !q.aw_full && !q.bvalid;
  assign wready  = !q.w_full && !q.bvalid;
  assign arready = !q.rvalid;
  assign wr_idx  = q.awaddr[5:2];
  assign rd_idx  = S_AXI_ARADDR_I[5:2];
  assign wr_map  = (q.awaddr[11:6] == 6'h00) && (wr_idx < 4'(NUM_CFG));
  assign rd_map  = (S_AXI_ARADDR_I[11:6] == 6'h00) && (rd_idx <= IDX_STATUS);

  always_comb begin
    status_word                          = '0;
    status_word[ST_T3]                   = q.t3_flt;
    status_word[ST_OCL]                  = q.ocl_flt;
    status_word[ST_SCL]                  = q.scl_flt;
    status_word[ST_OTC]                  = q.otc_flt;
    status_word[ST_OTD]                  = q.otd_flt;
    status_word[ST_OCD_REC]              = q.ocd_rec;
    status_word[ST_OCL_CNT +: 8]         = q.ocl_cnt;
    status_word[ST_SCL_CNT +: 8]         = q.scl_cnt;
  end

  always_comb begin
    logic       ocd_ev;
    logic       scd_ev;
    logic [7:0] ocl_n;
    logic [7:0] scl_n;
    ocd_ev = 1'b0;
    scd_ev = 1'b0;
    ocl_n  = 8'h00;
    scl_n  = 8'h00;
    d      = q;

    // One-second time base
    d.tick = 1'b0;
    if (q.tick_cnt == TICK_LAST) begin
      d.tick_cnt = '0;
      d.tick     = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + TICK_W'(1);
    end

    // Write address and data are taken independently
    if (S_AXI_AWVALID_I && awready) begin
      d.awaddr  = S_AXI_AWADDR_I;
      d.aw_full = 1'b1;
    end
    if (S_AXI_WVALID_I && wready) begin
      d.wdata  = S_AXI_WDATA_I;
      d.wstrb  = S_AXI_WSTRB_I;
      d.w_full = 1'b1;
    end
    if (q.bvalid && S_AXI_BREADY_I) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_full && q.w_full) begin
      d.aw_full = 1'b0;
      d.w_full  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      if (wr_map) begin
        for (int b = 0; b < 4; b++) begin
          if (q.wstrb[b]) begin
            d.cfg[wr_idx][8*b +: 8] = q.wdata[8*b +: 8] & CFG_MASK[wr_idx][8*b +: 8];
          end
        end
      end else if (!((q.awaddr[11:6] == 6'h00) && (wr_idx == IDX_STATUS))) begin
        d.bresp = RESP_SLVERR;
      end
    end

    // Reads
    if (q.rvalid && S_AXI_RREADY_I) begin
      d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && arready) begin
      d.rvalid = 1'b1;
      d.rresp  = rd_map ? RESP_OKAY : RESP_SLVERR;
      if (!rd_map) begin
        d.rdata = 32'h0000_0000;
      end else if (rd_idx == IDX_STATUS) begin
        d.rdata = status_word;
      end else begin
        d.rdata = q.cfg[rd_idx] & CFG_MASK[rd_idx];
      end
    end

    // Tier three fault: trip wins over shared recovery
    if (t_done[TM_T3]) begin
      d.t3_flt = 1'b1;                                                                       // [RL1]
    end else if (q.t3_flt && t_done[TM_OCD_REC]) begin
      d.t3_flt = 1'b0;                                                                       // [RL2]
    end
    d.ocd_rec = t_done[TM_OCD_REC];                                                          // [RL2]

    // Latch counters
    ocd_ev    = DISCHARGE_OVERCURRENT_EVENT_I || t_done[TM_T3];                              // [RL3]
    scd_ev    = DISCHARGE_SHORT_CIRCUIT_EVENT_I;                                             // [RL7]
    ocl_n     = step_cnt(q.ocl_cnt, ocd_ev, t_done[TM_OCL_DEC]);                             // [RL3] [RL4]
    scl_n     = step_cnt(q.scl_cnt, scd_ev, t_done[TM_SCL_DEC]);                             // [RL7] [RL4]
    d.ocl_cnt = ocl_n;
    d.scl_cnt = scl_n;

    // Latch faults: a new trip wins over a recovery in the same cycle
    if (ocd_ev && q.cfg[IDX_OCL_CFG][FLD_B0 +: 8] != 8'h00
        && ocl_n >= q.cfg[IDX_OCL_CFG][FLD_B0 +: 8]) begin
      d.ocl_flt = 1'b1;                                                                      // [RL3]
    end else if (t_done[TM_OCL_REC]) begin
      d.ocl_flt = 1'b0;                                                                      // [RL5] [RL6]
    end
    if (scd_ev && q.cfg[IDX_SCL_CFG][FLD_B0 +: 8] != 8'h00
        && scl_n >= q.cfg[IDX_SCL_CFG][FLD_B0 +: 8]) begin
      d.scl_flt = 1'b1;                                                                      // [RL7]
    end else if (t_done[TM_SCL_REC]) begin
      d.scl_flt = 1'b0;                                                                      // [RL8] [RL6]
    end

    // Overtemperature faults
    if (t_done[TM_OTC_SET]) begin
      d.otc_flt = 1'b1;                                                                      // [RL9]
    end else if (t_done[TM_OTC_REC]) begin
      d.otc_flt = 1'b0;                                                                      // [RL12]
    end
    if (t_done[TM_OTD_SET]) begin
      d.otd_flt = 1'b1;                                                                      // [RL13]
    end else if (t_done[TM_OTD_REC]) begin
      d.otd_flt = 1'b0;                                                                      // [RL16]
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  assign S_AXI_AWREADY_O = awready;
  assign S_AXI_WREADY_O  = wready;
  assign S_AXI_BVALID_O  = q.bvalid;
  assign S_AXI_BRESP_O   = q.bresp;
  assign S_AXI_ARREADY_O = arready;
  assign S_AXI_RVALID_O  = q.rvalid;
  assign S_AXI_RDATA_O   = q.rdata;
  assign S_AXI_RRESP_O   = q.rresp;

  assign DISCHARGE_OVERCURRENT_TIER_THREE_FAULT_O = q.t3_flt;
  assign DISCHARGE_OVERCURRENT_RECOVERED_O        = q.ocd_rec;
  assign DISCHARGE_OVERCURRENT_LATCH_FAULT_O      = q.ocl_flt;
  assign DISCHARGE_SHORT_CIRCUIT_LATCH_FAULT_O    = q.scl_flt;
  assign CHARGE_OVERTEMPERATURE_FAULT_O           = q.otc_flt;
  assign DISCHARGE_OVERTEMPERATURE_FAULT_O        = q.otd_flt;

endmodule : battery_fault_latch_protect
`default_nettype wire

// ### core/protect_pkg.sv
// Constants for the battery fault latch protection block.
// Assumes a 20 MHz core clock and a 32-bit AXI4-Lite register port.
package protect_pkg;

  // Time base
  localparam int CLK_PERIOD_NS = 50;
  localparam int ONE_SECOND_NS = 1_000_000_000;
  localparam int SECOND_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 25;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_T3_CFG    = 12'h004;
  localparam logic [11:0] OFS_OCD_REC   = 12'h008;
  localparam logic [11:0] OFS_OCL_CFG   = 12'h00c;
  localparam logic [11:0] OFS_OCL_REC   = 12'h010;
  localparam logic [11:0] OFS_SCL_CFG   = 12'h014;
  localparam logic [11:0] OFS_SCL_REC   = 12'h018;
  localparam logic [11:0] OFS_OTC_CFG   = 12'h01c;
  localparam logic [11:0] OFS_OTD_CFG   = 12'h020;
  localparam logic [11:0] OFS_STATUS    = 12'h024;

  // Register indices (offset / 4)
  localparam int NUM_CFG     = 9;
  localparam int IDX_CTRL    = 0;
  localparam int IDX_T3_CFG  = 1;
  localparam int IDX_OCD_REC = 2;
  localparam int IDX_OCL_CFG = 3;
  localparam int IDX_OCL_REC = 4;
  localparam int IDX_SCL_CFG = 5;
  localparam int IDX_SCL_REC = 6;
  localparam int IDX_OTC_CFG = 7;
  localparam int IDX_OTD_CFG = 8;
  localparam logic [3:0] IDX_STATUS = 4'h9;

  // Field positions
  localparam int CTRL_OCL_EN = 0;
  localparam int CTRL_SCL_EN = 1;
  localparam int FLD_B0      = 0;
  localparam int FLD_B1      = 8;
  localparam int FLD_B2      = 16;
  localparam int ST_T3       = 0;
  localparam int ST_OCL      = 1;
  localparam int ST_SCL      = 2;
  localparam int ST_OTC      = 3;
  localparam int ST_OTD      = 4;
  localparam int ST_OCD_REC  = 5;
  localparam int ST_OCL_CNT  = 8;
  localparam int ST_SCL_CNT  = 16;

  // Reset values, highest index first
  localparam logic [NUM_CFG-1:0][31:0] CFG_RESET = {
    32'h0037_023c,  // DISCHARGE_OVERTEMPERATURE: trip 60, delay 2 s, recover 55
    32'h0032_0237,  // CHARGE_OVERTEMPERATURE: trip 55, delay 2 s, recover 50
    32'h0000_00c8,  // SCL recovery threshold 200 mA
    32'h000f_0a00,  // SCL: limit 0, dec 10 s, recovery 15 s
    32'h0000_00c8,  // OCL recovery threshold 200 mA
    32'h000f_0a00,  // OCL: limit 0, dec 10 s, recovery 15 s
    32'h0000_00c8,  // Shared discharge overcurrent recovery 200 mA
    32'h0002_f060,  // Tier three: trip -4000, delay 2 s
    32'h0000_0000   // Current recovery enables off
  };
  localparam logic [NUM_CFG-1:0][31:0] CFG_MASK = {
    32'h00ff_ffff, 32'h00ff_ffff, 32'h0000_ffff, 32'h00ff_ffff, 32'h0000_ffff,
    32'h00ff_ffff, 32'h0000_ffff, 32'h00ff_ffff, 32'h0000_0003
  };

  // Persistence timer slots
  localparam int NUM_TIMERS = 10;
  localparam int TM_T3      = 0;
  localparam int TM_OCD_REC = 1;
  localparam int TM_OCL_REC = 2;
  localparam int TM_SCL_REC = 3;
  localparam int TM_OTC_SET = 4;
  localparam int TM_OTC_REC = 5;
  localparam int TM_OTD_SET = 6;
  localparam int TM_OTD_REC = 7;
  localparam int TM_OCL_DEC = 8;
  localparam int TM_SCL_DEC = 9;

  localparam logic [7:0] CNT_MAX     = 8'hff;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : protect_pkg

// ### core/persist_timer.sv
// Whole-second persistence timer.
// Assumes a one-cycle tick per second from the parent.
`timescale 1ns/10ps
`default_nettype none
module persist_timer
  import protect_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       tick_i,
  input  wire logic       cond_i,
  input  wire logic       clr_i,
  input  wire logic [7:0] limit_i,
  output logic            done_o
);

  typedef struct packed {
    logic [7:0] secs;
  } tmr_state_t;

  tmr_state_t q;
  tmr_state_t d;

  always_comb begin
    d = q;
    if (!cond_i || clr_i) begin
      d.secs = 8'h00;                         // [RL17]
    end else if (tick_i && q.secs != CNT_MAX) begin
      d.secs = q.secs + 8'h01;                // [RL17]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_o = cond_i && (q.secs >= limit_i);

endmodule : persist_timer
`default_nettype wire

// ### testbench/protect_chk_sva.sv
// Port checker for the battery fault latch protect block.
// Assumes tier three trip and temperature thresholds stay at reset values.
`timescale 1ns/10ps
`default_nettype none
module protect_chk (
  input wire logic        CORE_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic        S_AXI_BREADY_I,
  input wire logic [1:0]  S_AXI_BRESP_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [15:0] CURRENT_I,
  input wire logic [7:0]  MAX_CELL_TEMP_I,
  input wire logic        DISCHARGE_SHORT_CIRCUIT_EVENT_I,
  input wire logic        DISCHARGE_OVERCURRENT_TIER_THREE_FAULT_O,
  input wire logic        DISCHARGE_SHORT_CIRCUIT_LATCH_FAULT_O,
  input wire logic        CHARGE_OVERTEMPERATURE_FAULT_O,
  input wire logic        DISCHARGE_OVERTEMPERATURE_FAULT_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence wr_taken;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  sequence wr_answer;
    ##[1:2] S_AXI_BVALID_O;
  endsequence
  wr_resp_a: assert property (wr_taken |-> wr_answer)
    else $error("write response missing");
  bresp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write response not held");
  rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data not held");
  t3_rise_a: assert property ($rose(DISCHARGE_OVERCURRENT_TIER_THREE_FAULT_O) |->
    $signed($past(CURRENT_I)) <= -16'sd4000) else $error("tier three fault without overcurrent");
  scl_rise_a: assert property ($rose(DISCHARGE_SHORT_CIRCUIT_LATCH_FAULT_O) |->
    $past(DISCHARGE_SHORT_CIRCUIT_EVENT_I)) else $error("short latch fault without event");
  otc_rise_a: assert property ($rose(CHARGE_OVERTEMPERATURE_FAULT_O) |->
    $signed($past(MAX_CELL_TEMP_I)) >= 8'sd55) else $error("charge overtemp fault while cool");
  otc_fall_a: assert property ($fell(CHARGE_OVERTEMPERATURE_FAULT_O) |->
    $signed($past(MAX_CELL_TEMP_I)) <= 8'sd50) else $error("charge overtemp cleared while hot");
  otd_rise_a: assert property ($rose(DISCHARGE_OVERTEMPERATURE_FAULT_O) |->
    $signed($past(MAX_CELL_TEMP_I)) >= 8'sd60) else $error("discharge overtemp fault while cool");
  otd_fall_a: assert property ($fell(DISCHARGE_OVERTEMPERATURE_FAULT_O) |->
    $signed($past(MAX_CELL_TEMP_I)) <= 8'sd55) else $error("discharge overtemp cleared while hot");
endmodule : protect_chk
bind battery_fault_latch_protect protect_chk chk (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
  .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .CURRENT_I(CURRENT_I), .MAX_CELL_TEMP_I(MAX_CELL_TEMP_I),
  .DISCHARGE_SHORT_CIRCUIT_EVENT_I(DISCHARGE_SHORT_CIRCUIT_EVENT_I),
  .DISCHARGE_OVERCURRENT_TIER_THREE_FAULT_O(DISCHARGE_OVERCURRENT_TIER_THREE_FAULT_O),
  .DISCHARGE_SHORT_CIRCUIT_LATCH_FAULT_O(DISCHARGE_SHORT_CIRCUIT_LATCH_FAULT_O),
  .CHARGE_OVERTEMPERATURE_FAULT_O(CHARGE_OVERTEMPERATURE_FAULT_O),
  .DISCHARGE_OVERTEMPERATURE_FAULT_O(DISCHARGE_OVERTEMPERATURE_FAULT_O));
`default_nettype wire

// ### testbench/battery_fault_latch_protect_test.sv
// Self-checking bench for the battery fault latch protect block.
// Assumes a tick of 10 clocks stands for one second.
`timescale 1ns/10ps
`default_nettype none
module battery_fault_latch_protect_test import protect_pkg::*; ;
  localparam int TK = 10;
  logic        clk, rst_n, awv, wv, bready, arv, rready, oce, sce;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [15:0] cur;
  logic [7:0]  temp, rec_t;
  int          n_errors, checked, cyc = 0;
  wire         awrdy, wrdy, bv, arrdy, rv;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [5:0]  flt;
  battery_fault_latch_protect #(.TICK_CYCLES(TK)) dut (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arrdy), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rready), .CURRENT_I(cur), .MAX_CELL_TEMP_I(temp),
    .DISCHARGE_OVERCURRENT_EVENT_I(oce), .DISCHARGE_SHORT_CIRCUIT_EVENT_I(sce), .RECOVERY_TIME_I(rec_t),
    .DISCHARGE_OVERCURRENT_TIER_THREE_FAULT_O(flt[0]), .DISCHARGE_OVERCURRENT_RECOVERED_O(flt[1]),
    .DISCHARGE_OVERCURRENT_LATCH_FAULT_O(flt[2]), .DISCHARGE_SHORT_CIRCUIT_LATCH_FAULT_O(flt[3]),
    .CHARGE_OVERTEMPERATURE_FAULT_O(flt[4]), .DISCHARGE_OVERTEMPERATURE_FAULT_O(flt[5]));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic da, dw;
    da = 0;
    dw = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= s; awv <= 1; wv <= 1;
    while (!(da && dw)) begin
      @(negedge clk);
      da = da | awrdy;
      dw = dw | wrdy;
      @(posedge clk);
      if (da) awv <= 0;
      if (dw) wv <= 0;
    end
    do @(negedge clk); while (bv !== 1'b1);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge clk) bready <= 1;
    @(posedge clk) bready <= 0;
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a; arv <= 1;
    do @(negedge clk); while (arrdy !== 1'b1);
    @(posedge clk);
    arv <= 0;
    do @(negedge clk); while (rv !== 1'b1);
    chk("rdata", rdata, e);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    @(posedge clk) rready <= 1;
    @(posedge clk) rready <= 0;
  endtask : rc
  // Wait up to n cycles for a flag to reach v
  task automatic wf(input int i, input logic v, input int n);
    int k;
    k = 0;
    while (flt[i] !== v && k < n) begin
      @(negedge clk);
      k++;
    end
    chk($sformatf("flag%0d", i), {31'h0, flt[i]}, {31'h0, v});
  endtask : wf
  // Flag still v after n cycles
  task automatic stay(input int i, input logic v, input int n);
    repeat (n) @(negedge clk);
    chk($sformatf("flag%0d", i), {31'h0, flt[i]}, {31'h0, v});
  endtask : stay
  task automatic pulse(input logic sc);
    @(posedge clk);
    if (sc) sce <= 1;
    else oce <= 1;
    @(posedge clk);
    sce <= 0;
    oce <= 0;
  endtask : pulse
  initial begin
    n_errors = 0; checked = 0; rst_n = 0;
    awv = 0; wv = 0; bready = 0; arv = 0; rready = 0; oce = 0; sce = 0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = '0; cur = '0; temp = 8'h19; rec_t = 8'h02;
    repeat (8) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < NUM_CFG; i++) rc(12'(i * 4), CFG_RESET[i], RESP_OKAY);
    rc(OFS_STATUS, 32'h0, RESP_OKAY);
    rc(12'h040, 32'h0, RESP_SLVERR);
    wr(12'h040, 32'h1, 4'hf, RESP_SLVERR);
    wr(OFS_CTRL, 32'hffff_ffff, 4'hf, RESP_OKAY);
    rc(OFS_CTRL, 32'h3, RESP_OKAY);
    wr(OFS_CTRL, 32'h0, 4'hf, RESP_OKAY);
    // Overtemperature with no current flowing
    @(posedge clk) temp <= 8'h3c;
    stay(4, 0, 5);
    wf(4, 1, 40);
    wf(5, 1, 40);
    @(posedge clk) temp <= 8'h37;
    wf(5, 0, 60);
    stay(4, 1, 60);
    @(posedge clk) temp <= 8'h33;
    stay(4, 1, 60);
    @(posedge clk) temp <= 8'h32;
    wf(4, 0, 40);
    repeat (3) begin
      @(posedge clk) temp <= 8'h3c;
      repeat (8) @(posedge clk);
      temp <= 8'h19;
    end
    stay(4, 0, 3);
    wr(OFS_OTC_CFG, 32'h0032_0037, 4'hf, RESP_OKAY);
    @(posedge clk) temp <= 8'h37;
    wf(4, 1, 3);
    @(posedge clk) temp <= 8'h19;
    wf(4, 0, 40);
    // Overcurrent latch
    wr(OFS_OCL_CFG, 32'h000f_0a03, 4'hf, RESP_OKAY);
    pulse(0);
    pulse(0);
    stay(2, 0, 2);
    pulse(0);
    wf(2, 1, 3);
    rc(OFS_STATUS, 32'h0000_0302, RESP_OKAY);
    @(posedge clk) cur <= 16'h00c8;
    stay(2, 1, 150);
    rc(OFS_STATUS, 32'h0000_0222, RESP_OKAY);
    @(posedge clk) cur <= 16'h0000;
    wr(OFS_CTRL, 32'h1, 4'hf, RESP_OKAY);
    @(posedge clk) cur <= 16'h00c8;
    stay(2, 1, 130);
    wf(2, 0, 40);
    // Short-circuit latch
    wr(OFS_SCL_CFG, 32'h000f_0a01, 4'hf, RESP_OKAY);
    wr(OFS_CTRL, 32'h3, 4'hf, RESP_OKAY);
    pulse(1);
    wf(3, 1, 3);
    wf(3, 0, 170);
    // Tier three, delay 5 s through one byte lane
    @(posedge clk) cur <= 16'h0000;
    wr(OFS_T3_CFG, 32'h0005_0000, 4'h4, RESP_OKAY);
    @(posedge clk) cur <= 16'hf060;
    stay(0, 0, 40);
    wf(0, 1, 20);
    @(posedge clk) cur <= 16'h00c7;
    stay(0, 1, 40);
    @(posedge clk) cur <= 16'h00c8;
    wf(0, 0, 40);
    wf(1, 1, 1);
    results();
  end
endmodule : battery_fault_latch_protect_test
`default_nettype wire
